// file: cic_pkg.sv
// Constants and types shared by the interrupt control block.
// Assumes a 200 MHz pclk and an APB register port with 32-bit data.
package cic_pkg;
  localparam logic [11:0] CIC_CORE_CTRL_OFF   = 12'h02C;
  localparam logic [11:0] CIC_PERIPH_FLAG_OFF = 12'h030;
  // Odd printed offsets force index addressing: byte address is index * 4
  localparam logic [11:0] CIC_PERIPH_EN_IDX   = 12'h08C;
  localparam logic [11:0] CIC_PERIPH_EN_OFF   = 12'h230;
  localparam logic [11:0] CIC_PORT_EN_OFF     = 12'h096;
  localparam logic [11:0] CIC_OPTION_OFF      = 12'h034;
  localparam logic [11:0] CIC_STATUS_OFF      = 12'h038;
  // Port-change enables sit at 0x96, not a word multiple, so it is an index
  localparam logic [11:0] CIC_PORT_EN_IDX     = 12'h096;
  localparam logic [7:0]  CIC_CORE_RST        = 8'h00;
  localparam logic [7:0]  CIC_PERIPH_RST      = 8'h00;
  localparam logic [5:0]  CIC_PORT_EN_RST     = 6'h00;
  localparam int          CIC_GIE_BIT         = 7;
  localparam int          CIC_PERIPH_GROUP_ENABLE_BIT        = 6;
  localparam int          CIC_T0IE_BIT        = 5;
  localparam int          CIC_EXTE_BIT        = 4;
  localparam int          CIC_PCIE_BIT        = 3;
  localparam int          CIC_T0IF_BIT        = 2;
  localparam int          CIC_EXTF_BIT        = 1;
  localparam int          CIC_PCIF_BIT        = 0;
  localparam logic [7:0]  CIC_PERIPH_MASK     = 8'hFD;
  localparam logic [12:0] CIC_VECTOR          = 13'h0004;
  localparam int          CIC_TCY_NS          = 20;
  localparam int          CIC_CLK_NS          = 5;
  localparam int          CIC_TCY_CYCLES      = CIC_TCY_NS / CIC_CLK_NS;
  localparam int          CIC_PORT_W          = 6;
  typedef enum logic [3:0] {
    CIC_RUN    = 4'b0001,
    CIC_ARM    = 4'b0010,
    CIC_VEC    = 4'b0100,
    CIC_WAKE   = 4'b1000
  } cic_state_t;
endpackage

// file: cic_evt_if.sv
// Synchronised pin events passed from the pin stage to the main block.
// Assumes both ends run on pclk.
interface cic_evt_if;
  logic       ext_edge;
  logic       port_change;
  modport src (output ext_edge, output port_change);
  modport dst (input  ext_edge, input  port_change);
endinterface

// file: cic_pin_sync.sv
// Pin synchroniser and edge/change detector for the external pins.
// Assumes pins are asynchronous to pclk.
module cic_pin_sync #(
  parameter int PORT_W = cic_pkg::CIC_PORT_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ext_irq_pin,
  input  wire logic [PORT_W-1:0] port_pins,
  input  wire logic              ext_edge_select,
  input  wire logic [PORT_W-1:0] port_change_pin_enable_reg,
  cic_evt_if.src                 evt
);
  import cic_pkg::*;
  logic              ext_s1;
  logic              ext_s2;
  logic              ext_s3;
  logic [PORT_W-1:0] port_s1;
  logic [PORT_W-1:0] port_s2;
  logic [PORT_W-1:0] port_s3;

  initial begin
    if (PORT_W < 1) $error("PORT_W must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      port_s1 <= '0;
      port_s2 <= '0;
      port_s3 <= '0;
    end else begin
      ext_s1  <= ext_irq_pin;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      port_s1 <= port_pins;
      port_s2 <= port_s1;
      port_s3 <= port_s2;
    end
  end

  // Rising edge when select set, falling otherwise
  assign evt.ext_edge = ext_edge_select ? (ext_s2 & ~ext_s3)
                                        : (~ext_s2 & ext_s3);
  assign evt.port_change =
    |((port_s2 ^ port_s3) & port_change_pin_enable_reg);
endmodule

// file: cic_tcy_div.sv
// Instruction-cycle enable divider.
// Assumes pclk is free running.
module cic_tcy_div #(
  parameter int DIV = cic_pkg::CIC_TCY_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tcy_en
);
  logic [7:0] cnt;

  initial begin
    if (DIV < 1 || DIV > 256) $error("DIV out of range");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= 8'h00;
      tcy_en <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt    <= 8'h00;
      tcy_en <= 1'b1;
    end else begin
      cnt    <= cnt + 8'h01;
      tcy_en <= 1'b0;
    end
  end
endmodule

// file: cic_core.sv
// Interrupt control: flags, enables, vectoring, sleep wake-up, APB port.
// Assumes a core sequencer that acknowledges the vector and reports
// return-from-interrupt, sleep and global-enable-clear instructions.
// Contract
// - Service only while global enable set
// - Each source has own enable bit
// - Reset clears global enable
// - Return instruction sets global enable
// - Taking clears enable, pushes, vectors 0004h
// - Core register holds pin, change, timer0 flags
// - Peripheral flags: eeprom, comparators, timer1, clock
// - Peripheral enables match flag positions
// - Pin events vector in three-four cycles
// - Latency independent of instruction length
// - Flags set regardless of enables
// - After global clear, next-cycle request waits
// - Interrupt wake runs PC+1, then vectors
// - Wake leaves source flag set
// - Wake sets timeout, clears powerdown
// - External pin edge chosen by select
// - Port change only for enabled pins
// - Timer0 wrap sets its flag
module cic_core #(
  parameter int PORT_W = cic_pkg::CIC_PORT_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_irq_pin,
  input  wire logic [PORT_W-1:0] port_pins,
  input  wire logic              timer0_wrap,
  input  wire logic [7:0]        periph_events,
  input  wire logic              return_from_irq_instr,
  input  wire logic              gie_clear_instr,
  input  wire logic              sleep_instr,
  input  wire logic              vector_ack,
  output logic                   irq_take,
  output logic      [12:0]       vector_addr,
  output logic                   stack_push,
  output logic                   wake_exec_next,
  output logic                   sleeping
);
  import cic_pkg::*;

  logic [7:0]        core_irq_control_reg;
  logic [7:0]        periph_irq_flag_reg;
  logic [7:0]        periph_irq_enable_reg;
  logic [PORT_W-1:0] port_change_pin_enable_reg;
  logic              ext_edge_select;
  logic              timeout_flag;
  logic              powerdown_flag;
  logic              tcy_en;
  logic              block_next;
  logic              pend;
  cic_state_t        state;
  cic_evt_if         evt ();

  logic       wr;
  logic       rd;
  logic       hit_core;
  logic       hit_pflag;
  logic       hit_pen;
  logic       hit_port;
  logic       hit_opt;
  logic       hit_stat;
  logic       core_pend;
  logic       periph_pend;
  logic       any_src;
  logic [7:0] next_core;
  logic [7:0] next_pflag;

  initial begin
    if (PORT_W < 1 || PORT_W > 8) $error("PORT_W must be 1..8");
  end

  cic_pin_sync #(.PORT_W(PORT_W)) u_sync (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .ext_irq_pin                (ext_irq_pin),
    .port_pins                  (port_pins),
    .ext_edge_select            (ext_edge_select),
    .port_change_pin_enable_reg (port_change_pin_enable_reg),
    .evt                        (evt.src)
  );

  cic_tcy_div #(.DIV(CIC_TCY_CYCLES)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tcy_en  (tcy_en)
  );

  assign wr        = psel & penable & pwrite;
  assign rd        = psel & ~pwrite;
  assign hit_core  = paddr == CIC_CORE_CTRL_OFF;
  assign hit_pflag = paddr == CIC_PERIPH_FLAG_OFF;
  assign hit_pen   = paddr == CIC_PERIPH_EN_OFF;
  assign hit_port  = paddr == 12'((CIC_PORT_EN_IDX << 2));
  assign hit_opt   = paddr == CIC_OPTION_OFF;
  assign hit_stat  = paddr == CIC_STATUS_OFF;

  // Per-source masks, then peripheral group gate
  assign core_pend = |(core_irq_control_reg[2:0]
                       & core_irq_control_reg[5:3]);
  assign periph_pend = core_irq_control_reg[CIC_PERIPH_GROUP_ENABLE_BIT]
                     & |(periph_irq_flag_reg
                         & periph_irq_enable_reg);
  assign any_src = core_pend | periph_pend;

  // Set wins over a software clear in the same cycle
  always_comb begin
    next_core  = core_irq_control_reg;
    next_pflag = periph_irq_flag_reg;
    if (wr && hit_core) begin
      next_core[7:3] = pwdata[7:3];
      next_core[2:0] = pwdata[2:0];
    end
    if (wr && hit_pflag) begin
      next_pflag = pwdata[7:0] & CIC_PERIPH_MASK;
    end
    if (return_from_irq_instr) begin
      next_core[CIC_GIE_BIT] = 1'b1;
    end
    if (gie_clear_instr || (state == CIC_VEC && vector_ack)) begin
      next_core[CIC_GIE_BIT] = 1'b0;
    end
    if (evt.ext_edge) begin
      next_core[CIC_EXTF_BIT] = 1'b1;
    end
    if (evt.port_change) begin
      next_core[CIC_PCIF_BIT] = 1'b1;
    end
    if (timer0_wrap) begin
      next_core[CIC_T0IF_BIT] = 1'b1;
    end
    next_pflag = next_pflag | (periph_events & CIC_PERIPH_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_control_reg <= CIC_CORE_RST;
      periph_irq_flag_reg  <= CIC_PERIPH_RST;
    end else begin
      core_irq_control_reg <= next_core;
      periph_irq_flag_reg  <= next_pflag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enable_reg      <= CIC_PERIPH_RST;
      port_change_pin_enable_reg <= '0;
      ext_edge_select            <= 1'b1;
    end else if (wr) begin
      if (hit_pen) begin
        periph_irq_enable_reg <= pwdata[7:0] & CIC_PERIPH_MASK;
      end
      if (hit_port) begin
        port_change_pin_enable_reg <= pwdata[PORT_W-1:0];
      end
      if (hit_opt) begin
        ext_edge_select <= pwdata[0];
      end
    end
  end

  // Requests seen in the cycle after a global clear are held off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_next <= 1'b0;
    end else if (gie_clear_instr) begin
      block_next <= 1'b1;
    end else if (tcy_en) begin
      block_next <= 1'b0;
    end
  end

  // Flags sampled once per instruction cycle, one length for all
  // instructions so latency never tracks instruction size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
    end else if (tcy_en) begin
      pend <= any_src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= CIC_RUN;
      irq_take       <= 1'b0;
      stack_push     <= 1'b0;
      vector_addr    <= 13'h0000;
      wake_exec_next <= 1'b0;
      sleeping       <= 1'b0;
    end else begin
      stack_push     <= 1'b0;
      wake_exec_next <= 1'b0;
      case (state)
        CIC_RUN: begin
          if (sleep_instr) begin
            sleeping <= 1'b1;
            state    <= CIC_WAKE;
          // Live source check drops a sample made before software cleared
          end else if (tcy_en && pend && any_src && !block_next
                       && core_irq_control_reg[CIC_GIE_BIT]) begin
            state <= CIC_ARM;
          end
        end
        CIC_ARM: begin
          if (tcy_en) begin
            irq_take    <= 1'b1;
            stack_push  <= 1'b1;
            vector_addr <= CIC_VECTOR;
            state       <= CIC_VEC;
          end
        end
        CIC_VEC: begin
          if (vector_ack) begin
            irq_take <= 1'b0;
            state    <= CIC_RUN;
          end
        end
        CIC_WAKE: begin
          if (any_src) begin
            sleeping       <= 1'b0;
            wake_exec_next <= 1'b1;
            state          <= core_irq_control_reg[CIC_GIE_BIT]
                              ? CIC_ARM : CIC_RUN;
          end
        end
        default: state <= CIC_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (state == CIC_WAKE && any_src) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (sleep_instr) begin
      powerdown_flag <= 1'b0;
      timeout_flag   <= 1'b1;
    end
  end

  // Zero-wait slave; unmapped reads return zero with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_core | hit_pflag | hit_pen
                 | hit_port | hit_opt | hit_stat);
      prdata  <= 32'h0000_0000;
      if (rd && !penable) begin
        case (1'b1)
          hit_core:  prdata <= {24'h0, core_irq_control_reg};
          hit_pflag: prdata <= {24'h0, periph_irq_flag_reg};
          hit_pen:   prdata <= {24'h0, periph_irq_enable_reg};
          hit_port:  prdata <= 32'(port_change_pin_enable_reg);
          hit_opt:   prdata <= {31'h0, ext_edge_select};
          hit_stat:  prdata <= {27'h0, timeout_flag, powerdown_flag,
                                3'h0};
          default:   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence take_s;
    state == CIC_ARM && tcy_en;
  endsequence

  take_vec_a: assert property (take_s |=> irq_take && stack_push
    && vector_addr == CIC_VECTOR)
    else $error("vector not taken");
  gie_block_a: assert property (state == CIC_RUN && tcy_en
    && !core_irq_control_reg[CIC_GIE_BIT] && !sleep_instr
    |=> state != CIC_ARM)
    else $error("serviced with global enable clear");
  gie_ack_a: assert property (state == CIC_VEC && vector_ack
    && !return_from_irq_instr |=> !core_irq_control_reg[CIC_GIE_BIT])
    else $error("global enable kept after vector");
  reti_set_a: assert property (return_from_irq_instr && !gie_clear_instr
    && !(state == CIC_VEC && vector_ack)
    |=> core_irq_control_reg[CIC_GIE_BIT])
    else $error("return did not set global enable");
  ext_flag_a: assert property (evt.ext_edge
    |=> core_irq_control_reg[CIC_EXTF_BIT])
    else $error("pin flag not set");
  t0_flag_a: assert property (timer0_wrap
    |=> core_irq_control_reg[CIC_T0IF_BIT])
    else $error("timer0 flag not set");
  block_next_a: assert property (gie_clear_instr |=> state != CIC_ARM
    || $past(state) == CIC_ARM)
    else $error("request taken after clear");
  wake_stat_a: assert property (state == CIC_WAKE && any_src
    |=> timeout_flag && !powerdown_flag && wake_exec_next)
    else $error("wake status wrong");
  periph_gate_a: assert property (!core_irq_control_reg[CIC_PERIPH_GROUP_ENABLE_BIT]
    |-> !periph_pend)
    else $error("peripheral request passed group gate");
endmodule

// file: cic_seq_model.sv
// Core sequencer model: acknowledges vectors and records pushes.
// Assumes it shares pclk and presetn with the interrupt block.
module cic_seq_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        irq_take,
  input  wire logic        stack_push,
  input  wire logic [12:0] vector_addr,
  input  wire logic [3:0]  ack_delay,
  output logic             vector_ack,
  output int               push_count,
  output logic [12:0]      last_vector
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  // Slow answers come from ack_delay; one ack per take, never early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_ack <= 1'b0;
      wait_cnt   <= 4'h0;
    end else begin
      vector_ack <= 1'b0;
      if (irq_take === 1'b1 && !vector_ack) begin
        if (wait_cnt >= ack_delay) begin
          vector_ack <= 1'b1;
          wait_cnt   <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
  // Each stack push is counted; vector kept for comparison
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_count  <= 0;
      last_vector <= 13'h0000;
    end else if (stack_push === 1'b1) begin
      push_count  <= push_count + 1;
      last_vector <= vector_addr;
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the interrupt control block.
// Assumes cic_pkg and the sequencer model are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cic_pkg::*;
  localparam logic [11:0] PEN = {CIC_PORT_EN_IDX[9:0], 2'b00};
  localparam int          TCY = CIC_TCY_CYCLES;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext_pin, wrap, ret_i, gclr_i, sleep_i, vack, take, push, wake, slp;
  logic [CIC_PORT_W-1:0] pins;
  logic [7:0]  pev, en;
  logic [12:0] vaddr, last_vec;
  logic [3:0]  ack_delay;
  int push_count, num_errors, num_checks, cycles, wakes, p0, w0, n, b, g;

  cic_core i_cic_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(ext_pin), .port_pins(pins), .timer0_wrap(wrap),
    .periph_events(pev), .return_from_irq_instr(ret_i),
    .gie_clear_instr(gclr_i), .sleep_instr(sleep_i), .vector_ack(vack),
    .irq_take(take), .vector_addr(vaddr), .stack_push(push),
    .wake_exec_next(wake), .sleeping(slp));
  cic_seq_model i_cic_seq_model (.pclk(pclk), .presetn(presetn),
    .irq_take(take), .stack_push(push), .vector_addr(vaddr),
    .ack_delay(ack_delay), .vector_ack(vack), .push_count(push_count),
    .last_vector(last_vec));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (cycles == 30000) begin
      num_errors++;
      $display("unexpected timeout: expected end, seen hang");
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; an idle edge first keeps drivers single-assigned
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) check("pready", 1, 0);
  endtask
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask
  // Event or instruction held for one instruction cycle
  task automatic hit(int k, logic [7:0] v);
    @(posedge pclk);
    case (k)
      0: wrap <= 1'b1;
      1: ret_i <= 1'b1;
      2: sleep_i <= 1'b1;
      3: pev <= v;
      default: gclr_i <= 1'b1;
    endcase
    repeat (TCY) @(posedge pclk);
    wrap <= 1'b0; ret_i <= 1'b0; sleep_i <= 1'b0; pev <= 8'h00;
    gclr_i <= 1'b0;
  endtask
  task automatic tcy(int k);
    repeat (k * TCY) @(posedge pclk);
  endtask
  task automatic pin_chk(logic v, logic [31:0] e);
    @(posedge pclk) ext_pin <= v;
    tcy(4);
    rchk("ext_flag", CIC_CORE_CTRL_OFF, e);
  endtask

  initial begin
    void'($urandom(32'h05109361));
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_pin, pins} = '0;
    {wrap, ret_i, gclr_i, sleep_i, pev, ack_delay} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("core_rst", CIC_CORE_CTRL_OFF, 32'h00);
    rchk("pen_rst", CIC_PERIPH_EN_OFF, 32'h00);
    rchk("port_rst", PEN, 32'h00);
    rchk("edge_rst", CIC_OPTION_OFF, 32'h01);
    apb(1'b0, 12'h0F0, 32'h0);
    check("slverr", 1, err);
    // Flag sets with every enable off; serviced only once global enable is set
    hit(0, 0);
    tcy(3);
    rchk("t0_flag", CIC_CORE_CTRL_OFF, 32'h04);
    apb(1'b1, CIC_CORE_CTRL_OFF, 32'h24);
    tcy(3);
    check("no_take", 0, push_count);
    ack_delay <= 4'h3;
    apb(1'b1, CIC_CORE_CTRL_OFF, 32'hA4);
    tcy(4);
    check("take", 1, push_count);
    check("vector", CIC_VECTOR, last_vec);
    tcy(2);
    rchk("gie_clr", CIC_CORE_CTRL_OFF, 32'h24);
    apb(1'b1, CIC_CORE_CTRL_OFF, 32'h20);
    hit(1, 0);
    tcy(3);
    rchk("ret_gie", CIC_CORE_CTRL_OFF, 32'hA0);
    check("no_retake", 1, push_count);
    hit(4, 0);
    rchk("gclr", CIC_CORE_CTRL_OFF, 32'h20);
    // Peripheral sources under random enables and group enable
    ack_delay <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      en = 8'($urandom) & CIC_PERIPH_MASK;
      g = (i == 0) ? 0 : int'($urandom_range(1, 0));
      b = (i == 1) ? 1 : int'($urandom_range(7, 0));
      if (i == 0) en = CIC_PERIPH_MASK;
      apb(1'b1, CIC_CORE_CTRL_OFF, {24'h0, 1'b1, g[0], 6'h00});
      apb(1'b1, CIC_PERIPH_EN_OFF, {24'h0, en});
      rchk("pen_rw", CIC_PERIPH_EN_OFF, {24'h0, en});
      p0 = push_count;
      hit(3, 8'(1 << b) | 8'h02);
      tcy(4);
      rchk("pflag", CIC_PERIPH_FLAG_OFF,
           {24'h0, 8'(1 << b) & CIC_PERIPH_MASK});
      check("ptake", {31'h0, en[b] & g[0]}, push_count - p0);
      apb(1'b1, CIC_PERIPH_FLAG_OFF, 32'h0);
    end
    // External pin: latency, then edge selection both ways
    apb(1'b1, CIC_CORE_CTRL_OFF, 32'h90);
    @(posedge pclk) ext_pin <= 1'b1;
    n = 0;
    while (take !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
    check("ext_lat", 1, n >= 2 * TCY && n <= 4 * TCY + 2);
    tcy(2);
    rchk("ext_ack", CIC_CORE_CTRL_OFF, 32'h12);
    apb(1'b1, CIC_CORE_CTRL_OFF, 32'h10);
    pin_chk(1'b0, 32'h10);
    apb(1'b1, CIC_OPTION_OFF, 32'h0);
    pin_chk(1'b1, 32'h10);
    pin_chk(1'b0, 32'h12);
    // Port change only on enabled pins
    for (int i = 0; i < 6; i++) begin
      en = 8'($urandom) & 8'h3F;
      b = int'($urandom_range(5, 0));
      apb(1'b1, CIC_CORE_CTRL_OFF, 32'h08);
      apb(1'b1, PEN, {24'h0, en});
      @(posedge pclk) pins <= pins ^ 6'(1 << b);
      tcy(3);
      rchk("pc_flag", CIC_CORE_CTRL_OFF, {28'h0, 3'h4, en[b]});
    end
    // Sleep wake-up without and with the global enable
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, CIC_CORE_CTRL_OFF, k ? 32'hA0 : 32'h20);
      hit(2, 0);
      tcy(1);
      check("sleep", 1, slp);
      p0 = push_count;
      w0 = wakes;
      hit(0, 0);
      tcy(5);
      check("woke", 0, slp);
      check("wake_pulse", 1, wakes - w0);
      check("wake_vec", k, push_count - p0);
      rchk("wake_src", CIC_CORE_CTRL_OFF, 32'h24);
      apb(1'b0, CIC_STATUS_OFF, 32'h0);
      check("wake_stat", 32'h10, rd & 32'h18);
    end
    end_of_test();
  end
endmodule
